// ===== shared/gsso_map.svh
// constant map for the geometry stream-out index and statistics block
`ifndef GSSO_MAP_SVH
`define GSSO_MAP_SVH
`define GSSO_ADDR_CTRL 8'h00
`define GSSO_ADDR_IDX0 8'h04
`define GSSO_ADDR_IDX1 8'h08
`define GSSO_ADDR_IDX2 8'h0C
`define GSSO_ADDR_IDX3 8'h10
`define GSSO_ADDR_INV 8'h14
`define GSSO_ADDR_PRIM 8'h18
`define GSSO_ADDR_STOR 8'h1C
`define GSSO_ADDR_STAT 8'h20
`define GSSO_ADDR_OUTC 8'h24
`define GSSO_BIT_SVB_EN 0
`define GSSO_BIT_STAT_EN 1
`define GSSO_RESP_OKAY 2'h0
`define GSSO_RESP_SLVERR 2'h2
`define GSSO_ZERO32 32'h0000_0000
`define GSSO_ONE32 32'h0000_0001
`define GSSO_NUM_IDX 4
`endif

// ===== shared/gsso_pkg.sv
// types for the geometry stream-out index and statistics block
package gsso_pkg;
  typedef enum logic [2:0] {
    GSSO_IDLE = 3'b001,
    GSSO_FETCH = 3'b010,
    GSSO_WAIT = 3'b100
  } gsso_load_t;
endpackage

// ===== hw/gsso_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "gsso_map.svh"
module gsso_skid
  import gsso_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data
);
  logic [31:0] mem_reg [0:1];
  logic [31:0] mem_next [0:1];
  logic wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;
  logic rdy_reg, rdy_next;

  assign in_ready = rdy_reg;
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    if (push) begin
      mem_next[wp_reg] = in_data;
    end
    wp_next = push ? ~wp_reg : wp_reg;
    rp_next = pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    rdy_next = (cnt_next != 2'd2);
  end

  always_ff @(posedge clk) begin
    mem_reg[0] <= mem_next[0];
    mem_reg[1] <= mem_next[1];
    if (!nrst) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'd0;
      rdy_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  a_skid_no_over: assert property (@(posedge clk) disable iff (!nrst)
    cnt_reg <= 2'd2) else $error("buffer count above two");
endmodule

// ===== hw/gsso_top.sv
// geometry stage stream-out indices, ordering and statistics
`timescale 1ns/100ps
`include "gsso_map.svh"
module gsso_top
  import gsso_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // axi4-lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // thread dispatch
  input wire logic DISPATCH,
  output logic PAYLOAD_VALID,
  output logic [127:0] PAYLOAD_R1,
  // load command
  input wire logic LOAD_CMD,
  input wire logic LOAD_INDIRECT,
  input wire logic [127:0] LOAD_VALUES,
  output logic FETCH_REQ,
  input wire logic FETCH_DONE,
  input wire logic [127:0] FETCH_DATA,
  // stream buffer write message
  input wire logic SBW_VALID,
  input wire logic SBW_INC_IDX,
  input wire logic SBW_INC_PRIM,
  input wire logic SBW_INC_STOR,
  // thread ordering
  input wire logic THREAD_END,
  input wire logic OUT_THREAD_HEAD,
  output logic OUT_GRANT,
  // vertex header readback
  input wire logic HDR_VALID,
  output logic HDR_READY,
  input wire logic [31:0] HDR_DATA,
  output logic CLIP_VALID,
  input wire logic CLIP_READY,
  output logic [31:0] CLIP_DATA
);
  logic [31:0] idx_reg [0:3];
  logic [31:0] idx_next [0:3];
  logic [31:0] ctrl_reg, ctrl_next, inv_reg, inv_next;
  logic [31:0] prim_reg, prim_next, stor_reg, stor_next;
  logic [31:0] outc_reg, outc_next;
  gsso_load_t ld_reg, ld_next;
  logic pv_reg, pv_next, fr_reg, fr_next, gr_reg, gr_next;
  logic [127:0] r1_reg, r1_next;
  logic [7:0] done_cnt_reg, done_cnt_next, disp_cnt_reg, disp_cnt_next;
  logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic r_reg, r_next;
  logic [31:0] rd_reg, rd_next;
  logic sw_load;
  logic [127:0] sw_vals;
  logic cv_int;
  logic [31:0] cd_int;
  logic cv_reg, cv_next;
  logic [31:0] cd_reg, cd_next;
  logic sk_ready;
  logic awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, arrdy_reg, arrdy_next;

  // header readback path into the clip stage
  gsso_skid u_skid (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(HDR_VALID),
    .in_ready(sk_ready),
    .in_data(HDR_DATA),
    .out_valid(cv_int),
    .out_ready(!cv_reg || CLIP_READY),
    .out_data(cd_int)
  );

  always_comb begin
    cv_next = cv_reg;
    cd_next = cd_reg;
    if (!cv_reg || CLIP_READY) begin
      cv_next = cv_int;
      cd_next = cd_int;
    end
  end

  // axi write channel
  always_comb begin
    aw_next = aw_reg;
    awa_next = awa_reg;
    w_next = w_reg;
    wd_next = wd_reg;
    b_next = b_reg;
    br_next = br_reg;
    sw_load = 1'b0;
    if (AWVALID && !aw_reg && !b_reg) begin
      aw_next = 1'b1;
      awa_next = AWADDR;
    end
    if (WVALID && !w_reg && !b_reg) begin
      w_next = 1'b1;
      wd_next = WDATA;
    end
    if (aw_reg && w_reg && !b_reg) begin
      b_next = 1'b1;
      aw_next = 1'b0;
      w_next = 1'b0;
      br_next = `GSSO_RESP_OKAY;
      case (awa_reg)
        `GSSO_ADDR_CTRL, `GSSO_ADDR_IDX0, `GSSO_ADDR_IDX1,
        `GSSO_ADDR_IDX2, `GSSO_ADDR_IDX3: sw_load = 1'b1;
        default: br_next = `GSSO_RESP_SLVERR;
      endcase
    end
    if (b_reg && BREADY) begin
      b_next = 1'b0;
    end
    awrdy_next = !aw_next && !b_next;
    wrdy_next = !w_next && !b_next;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (sw_load && awa_reg == `GSSO_ADDR_CTRL) begin
      ctrl_next = wd_reg;
    end
  end

  // read channel
  always_comb begin
    r_next = r_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (ARVALID && !r_reg) begin
      r_next = 1'b1;
      rr_next = `GSSO_RESP_OKAY;
      case (ARADDR)
        `GSSO_ADDR_CTRL: rd_next = ctrl_reg;
        `GSSO_ADDR_IDX0: rd_next = idx_reg[0];
        `GSSO_ADDR_IDX1: rd_next = idx_reg[1];
        `GSSO_ADDR_IDX2: rd_next = idx_reg[2];
        `GSSO_ADDR_IDX3: rd_next = idx_reg[3];
        `GSSO_ADDR_INV: rd_next = inv_reg;
        `GSSO_ADDR_PRIM: rd_next = prim_reg;
        `GSSO_ADDR_STOR: rd_next = stor_reg;
        `GSSO_ADDR_STAT: rd_next = {29'h0, ld_reg};
        `GSSO_ADDR_OUTC: rd_next = outc_reg;
        default: begin
          rd_next = `GSSO_ZERO32;
          rr_next = `GSSO_RESP_SLVERR;
        end
      endcase
    end else if (r_reg && RREADY) begin
      r_next = 1'b0;
    end
    arrdy_next = !r_next;
  end

  // load command state machine
  always_comb begin
    ld_next = ld_reg;
    fr_next = 1'b0;
    sw_vals = LOAD_VALUES;
    case (ld_reg)
      GSSO_IDLE: begin
        if (LOAD_CMD && LOAD_INDIRECT) begin
          ld_next = GSSO_FETCH;
        end
      end
      GSSO_FETCH: begin
        fr_next = 1'b1;
        ld_next = GSSO_WAIT;
      end
      GSSO_WAIT: begin
        if (FETCH_DONE) begin
          ld_next = GSSO_IDLE;
          sw_vals = FETCH_DATA;
        end
      end
      default: ld_next = GSSO_IDLE;
    endcase
  end

  // held indices persist, load beats increment
  generate
    for (genvar i = 0; i < `GSSO_NUM_IDX; i++) begin : g_idx
      always_comb begin
        idx_next[i] = idx_reg[i];
        if (SBW_VALID && SBW_INC_IDX) begin
          idx_next[i] = idx_reg[i] + `GSSO_ONE32;
        end
        if ((LOAD_CMD && !LOAD_INDIRECT && ld_reg == GSSO_IDLE) ||
            (ld_reg == GSSO_WAIT && FETCH_DONE)) begin
          idx_next[i] = sw_vals[32*i +: 32];
        end
        if (sw_load && awa_reg == `GSSO_ADDR_IDX0 + 8'(4 * i)) begin
          idx_next[i] = wd_reg;
        end
      end
    end
  endgenerate

  // snapshot indices at dispatch time only
  always_comb begin
    pv_next = DISPATCH;
    r1_next = r1_reg;
    if (DISPATCH) begin
      r1_next = ctrl_reg[`GSSO_BIT_SVB_EN] ?
        {idx_reg[3], idx_reg[2], idx_reg[1], idx_reg[0]} : 128'h0;
    end
  end

  // statistics counters
  always_comb begin
    inv_next = inv_reg;
    prim_next = prim_reg;
    stor_next = stor_reg;
    if (DISPATCH && ctrl_reg[`GSSO_BIT_STAT_EN]) begin
      inv_next = inv_reg + `GSSO_ONE32;
    end
    if (SBW_VALID && SBW_INC_PRIM) begin
      prim_next = prim_reg + `GSSO_ONE32;
    end
    if (SBW_VALID && SBW_INC_STOR) begin
      stor_next = stor_reg + `GSSO_ONE32;
    end
  end

  // grant output only to oldest unfinished thread
  always_comb begin
    disp_cnt_next = disp_cnt_reg + {7'h0, DISPATCH};
    done_cnt_next = done_cnt_reg + {7'h0, THREAD_END};
    gr_next = OUT_THREAD_HEAD && (done_cnt_reg != disp_cnt_reg);
    outc_next = outc_reg + {31'h0, gr_reg};
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      for (int k = 0; k < `GSSO_NUM_IDX; k++) begin
        idx_reg[k] <= `GSSO_ZERO32;
      end
      ctrl_reg <= `GSSO_ZERO32;
      inv_reg <= `GSSO_ZERO32;
      prim_reg <= `GSSO_ZERO32;
      stor_reg <= `GSSO_ZERO32;
      outc_reg <= `GSSO_ZERO32;
      ld_reg <= GSSO_IDLE;
      pv_reg <= 1'b0;
      fr_reg <= 1'b0;
      gr_reg <= 1'b0;
      r1_reg <= 128'h0;
      disp_cnt_reg <= 8'h00;
      done_cnt_reg <= 8'h00;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      b_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= `GSSO_ZERO32;
      br_reg <= 2'h0;
      r_reg <= 1'b0;
      rd_reg <= `GSSO_ZERO32;
      rr_reg <= 2'h0;
      cv_reg <= 1'b0;
      cd_reg <= `GSSO_ZERO32;
      awrdy_reg <= 1'b1;
      wrdy_reg <= 1'b1;
      arrdy_reg <= 1'b1;
    end else begin
      for (int k = 0; k < `GSSO_NUM_IDX; k++) begin
        idx_reg[k] <= idx_next[k];
      end
      ctrl_reg <= ctrl_next;
      inv_reg <= inv_next;
      prim_reg <= prim_next;
      stor_reg <= stor_next;
      outc_reg <= outc_next;
      ld_reg <= ld_next;
      pv_reg <= pv_next;
      fr_reg <= fr_next;
      gr_reg <= gr_next;
      r1_reg <= r1_next;
      disp_cnt_reg <= disp_cnt_next;
      done_cnt_reg <= done_cnt_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      b_reg <= b_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      br_reg <= br_next;
      r_reg <= r_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      cv_reg <= cv_next;
      cd_reg <= cd_next;
      awrdy_reg <= awrdy_next;
      wrdy_reg <= wrdy_next;
      arrdy_reg <= arrdy_next;
    end
  end

  assign AWREADY = awrdy_reg;
  assign WREADY = wrdy_reg;
  assign BVALID = b_reg;
  assign BRESP = br_reg;
  assign ARREADY = arrdy_reg;
  assign RVALID = r_reg;
  assign RDATA = rd_reg;
  assign RRESP = rr_reg;
  assign PAYLOAD_VALID = pv_reg;
  assign PAYLOAD_R1 = r1_reg;
  assign FETCH_REQ = fr_reg;
  assign OUT_GRANT = gr_reg;
  assign HDR_READY = sk_ready;
  assign CLIP_VALID = cv_reg;
  assign CLIP_DATA = cd_reg;

  a_inv_gated: assert property (@(posedge CLK) disable iff (!NRST)
    (DISPATCH && !ctrl_reg[`GSSO_BIT_STAT_EN]) |=> $stable(inv_reg))
    else $error("invocation counter moved while disabled");
  a_prim_count: assert property (@(posedge CLK) disable iff (!NRST)
    (SBW_VALID && SBW_INC_PRIM) |=>
    prim_reg == $past(prim_reg) + `GSSO_ONE32)
    else $error("primitives written did not step");
  a_stor_count: assert property (@(posedge CLK) disable iff (!NRST)
    (SBW_VALID && SBW_INC_STOR) |=>
    stor_reg == $past(stor_reg) + `GSSO_ONE32)
    else $error("storage needed did not step");
  a_payload_off: assert property (@(posedge CLK) disable iff (!NRST)
    (DISPATCH && !ctrl_reg[`GSSO_BIT_SVB_EN]) |=> PAYLOAD_R1 == 128'h0)
    else $error("indices passed while disabled");
  a_idx_adv: assert property (@(posedge CLK) disable iff (!NRST)
    (SBW_VALID && SBW_INC_IDX && !LOAD_CMD && ld_reg == GSSO_IDLE &&
     !sw_load) |=> idx_reg[0] == $past(idx_reg[0]) + `GSSO_ONE32)
    else $error("index did not advance");
  a_idx_hold: assert property (@(posedge CLK) disable iff (!NRST)
    (!SBW_VALID && !LOAD_CMD && ld_reg == GSSO_IDLE && !sw_load)
    |=> $stable(idx_reg[1]))
    else $error("index changed without cause");
  a_load_direct: assert property (@(posedge CLK) disable iff (!NRST)
    (LOAD_CMD && !LOAD_INDIRECT && ld_reg == GSSO_IDLE && !sw_load)
    |=> idx_reg[2] == $past(LOAD_VALUES[95:64]))
    else $error("direct load not taken");
  a_fetch_seq: assert property (@(posedge CLK) disable iff (!NRST)
    (LOAD_CMD && LOAD_INDIRECT && ld_reg == GSSO_IDLE)
    |=> ##1 FETCH_REQ)
    else $error("fetch not requested");
  a_grant_order: assert property (@(posedge CLK) disable iff (!NRST)
    OUT_GRANT |-> $past(done_cnt_reg != disp_cnt_reg))
    else $error("grant with no live thread");
  a_snap_dispatch: assert property (@(posedge CLK) disable iff (!NRST)
    (DISPATCH && ctrl_reg[`GSSO_BIT_SVB_EN]) |=>
    PAYLOAD_R1[31:0] == $past(idx_reg[0]))
    else $error("payload not dispatch snapshot");
endmodule

// ===== tb/gsso_far.sv
// far-side model: memory fetch answer and vertex header source
`timescale 1ns/100ps
module gsso_far (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // memory fetch
  input wire logic freq,
  input wire logic [3:0] dly,
  input wire logic [127:0] mem,
  output logic fdone,
  output logic [127:0] fdata,
  // header source
  output logic hv,
  input wire logic hr,
  output logic [31:0] hd
);
  logic [31:0] hq[$];
  logic [3:0] cnt;
  logic busy;
  task automatic push(input logic [31:0] d);
    hq.push_back(d);
  endtask
  always @(posedge clk) begin
    if (!nrst) begin
      busy <= 1'h0;
      fdone <= 1'h0;
      fdata <= 128'h0;
      hv <= 1'h0;
      hd <= 32'h0;
    end else begin
      fdone <= 1'h0;
      if (freq) begin
        busy <= 1'h1;
        cnt <= dly;
      end else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (busy) begin
        busy <= 1'h0;
        fdone <= 1'h1;
        fdata <= mem;
      end
      // released data is not left standing
      if (fdone)
        fdata <= ~fdata;
      // an accepted entry is dropped and its data inverted unless another is queued
      if (hv && hr) begin
        hv <= 1'h0;
        hd <= ~hd;
      end
      if ((!hv || hr) && hq.size() > 0) begin
        hv <= 1'h1;
        hd <= hq.pop_front();
      end
    end
  end
endmodule

// ===== tb/gsso_top_test.sv
// self-checking bench for the stream-out index block
`timescale 1ns/100ps
`include "gsso_map.svh"
module gsso_top_test;
  localparam logic [1:0] rok = `GSSO_RESP_OKAY;
  localparam logic [1:0] rerr = `GSSO_RESP_SLVERR;
  logic clk = 1'b0;
  logic nrst, awv, wv, brdy, arv, rrdy, disp, ldc, ldi, sbw;
  logic qi, qp, qs, tend, head, crdy, stall;
  logic awr, wrr, bv, arr, rv, pv, freq, fdone, grant, hv, hr, cv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, hd, cd;
  logic [127:0] ldv, mem, r1, fd, idx;
  logic [1:0] bresp, rresp;
  logic [3:0] dly;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [127:0] pq[$];
  logic [31:0] cq[$];
  logic [31:0] seed = 32'h0000_9f2c;
  int n_errors = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  gsso_top dut (.CLK(clk), .NRST(nrst), .AWADDR(awa), .AWVALID(awv),
    .AWREADY(awr), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrr),
    .BRESP(bresp), .BVALID(bv), .BREADY(brdy), .ARADDR(ara),
    .ARVALID(arv), .ARREADY(arr), .RDATA(rdat), .RRESP(rresp),
    .RVALID(rv), .RREADY(rrdy), .DISPATCH(disp), .PAYLOAD_VALID(pv),
    .PAYLOAD_R1(r1), .LOAD_CMD(ldc), .LOAD_INDIRECT(ldi),
    .LOAD_VALUES(ldv), .FETCH_REQ(freq), .FETCH_DONE(fdone),
    .FETCH_DATA(fd), .SBW_VALID(sbw), .SBW_INC_IDX(qi),
    .SBW_INC_PRIM(qp), .SBW_INC_STOR(qs), .THREAD_END(tend),
    .OUT_THREAD_HEAD(head), .OUT_GRANT(grant), .HDR_VALID(hv),
    .HDR_READY(hr), .HDR_DATA(hd), .CLIP_VALID(cv), .CLIP_READY(crdy),
    .CLIP_DATA(cd));
  gsso_far far (.clk(clk), .nrst(nrst), .freq(freq), .dly(dly),
    .mem(mem), .fdone(fdone), .fdata(fd), .hv(hv), .hr(hr), .hd(hd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [127:0] bump(input logic [127:0] v, int n);
    for (int k = 0; k < 4; k++)
      v[k*32 +: 32] += 32'(n);
    return v;
  endfunction
  task automatic check(input string nm, input logic [127:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    finish_test();
  endtask
  // results noted by the drivers are compared as they appear
  always @(posedge clk) begin
    if (bv && brdy)
      check("bresp", bresp, bq.size() ? bq.pop_front() : 'x);
    if (rv && rrdy)
      check("read", {rresp, rdat}, rq.size() ? rq.pop_front() : 'x);
    if (pv)
      check("payload", r1, pq.size() ? pq.pop_front() : 'x);
    if (cv && crdy)
      check("clip", cd, cq.size() ? cq.pop_front() : 'x);
    crdy <= stall ? 1'h0 : 1'(rnd() >> 7);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] rs);
    bq.push_back(rs);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50)
        hang();
      @(posedge clk);
      if (awv && awr)
        awv <= 1'h0;
      if (wv && wrr)
        wv <= 1'h0;
      if (bv)
        break;
    end
    brdy <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] rs,
      input logic [31:0] d);
    rq.push_back({rs, d});
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50)
        hang();
      @(posedge clk);
      if (arv && arr)
        arv <= 1'h0;
      if (rv)
        break;
    end
    rrdy <= 1'h0;
    @(posedge clk);
  endtask
  // one dispatch at a time, never overlapped
  task automatic dsp(input logic [127:0] e);
    pq.push_back(e);
    disp <= 1'h1;
    @(posedge clk);
    disp <= 1'h0;
    @(posedge clk);
  endtask
  // thread flags the advance it wants
  task automatic msg(input logic i, p, s);
    sbw <= 1'h1;
    qi <= i;
    qp <= p;
    qs <= s;
    @(posedge clk);
  endtask
  task automatic load(input logic ind, input logic [127:0] v);
    ldi <= ind;
    ldv <= v;
    ldc <= 1'h1;
    @(posedge clk);
    ldc <= 1'h0;
    @(posedge clk);
  endtask
  task automatic hdr();
    logic [31:0] d;
    d = rnd();
    cq.push_back(d);
    far.push(d);
  endtask
  initial begin
    {awv, wv, brdy, arv, rrdy, disp, ldc, ldi, sbw} = '0;
    {qi, qp, qs, tend, head, nrst} = '0;
    {awa, ara, wd, ldv, mem, dly} = '0;
    stall = 1'h1;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(`GSSO_ADDR_CTRL, rok, `GSSO_ZERO32);
    rd(`GSSO_ADDR_STAT, rok, `GSSO_ONE32);
    rd(8'h28, rerr, `GSSO_ZERO32);
    wr(`GSSO_ADDR_INV, `GSSO_ONE32, rerr);
    rd(`GSSO_ADDR_INV, rok, `GSSO_ZERO32);
    $display("test registers done");
    idx = {rnd(), rnd(), rnd(), rnd()};
    load(1'h0, idx);
    dsp(128'h0);
    // turn on both the index payload and statistics enables
    wr(`GSSO_ADDR_CTRL, 32'h0000_0003, rok);
    dsp(idx);
    rd(`GSSO_ADDR_INV, rok, `GSSO_ONE32);
    rd(`GSSO_ADDR_IDX3, rok, idx[127:96]);
    $display("test direct load done");
    msg(1'h1, 1'h1, 1'h0);
    msg(1'h1, 1'h0, 1'h1);
    msg(1'h0, 1'h1, 1'h1);
    sbw <= 1'h0;
    wr(`GSSO_ADDR_CTRL, `GSSO_ONE32, rok);
    idx = bump(idx, 2);
    dsp(idx);
    rd(`GSSO_ADDR_INV, rok, `GSSO_ONE32);
    rd(`GSSO_ADDR_PRIM, rok, 32'h0000_0002);
    rd(`GSSO_ADDR_STOR, rok, 32'h0000_0002);
    $display("test increment done");
    mem <= {rnd(), rnd(), rnd(), rnd()};
    dly <= 4'h6;
    load(1'h1, ~idx);
    check("held", r1, idx);
    for (int i = 0; i <= 40 && !fdone; i++) begin
      if (i == 40)
        hang();
      @(posedge clk);
    end
    @(posedge clk);
    dsp(mem);
    idx = mem;
    idx[63:32] = rnd();
    wr(`GSSO_ADDR_IDX1, idx[63:32], rok);
    rd(`GSSO_ADDR_IDX1, rok, idx[63:32]);
    $display("test indirect load done");
    head <= 1'h1;
    repeat (2) @(posedge clk);
    check("grant", grant, 1'h1);
    head <= 1'h0;
    repeat (2) @(posedge clk);
    check("grant", grant, 1'h0);
    // four end cycles retire the four dispatched threads
    tend <= 1'h1;
    repeat (4) @(posedge clk);
    tend <= 1'h0;
    head <= 1'h1;
    repeat (2) @(posedge clk);
    check("grant", grant, 1'h0);
    head <= 1'h0;
    rd(`GSSO_ADDR_OUTC, rok, 32'h0000_0002);
    $display("test ordering done");
    for (int i = 0; i < 4; i++)
      hdr();
    repeat (10) @(posedge clk);
    check("hdr full", hr, 1'h0);
    stall <= 1'h0;
    for (int i = 0; i < 20; i++)
      hdr();
    for (int i = 0; i <= 300 && cq.size() > 0; i++) begin
      if (i == 300)
        hang();
      @(posedge clk);
    end
    $display("test header done");
    finish_test();
  end
endmodule
